/* File: olf_office_fsm.sv */
// Office-side activation/deactivation controller with an APB register file.
// Assumes line status, frame header bits and message acknowledgements are
// synchronous to ref_clk_i; the message channel itself lives outside.
`timescale 1ns/1ps
// Overview of operation
// - Start in power-up; quiet, power-up request, loss or timeout in converge/search re-enter it.
// - Power-up sends quiet and loads current parameters from the stored copy.
// - Leave power-up for standby after signal loss outlasts the quiet-detection time.
// - Quiet-detection time is programmable between 10 ms and 100 ms.
// - Standby sends quiet; connect control or upstream energy requests activation.
// - Enabled disconnect control blocks remote-originated activation in standby.
// - Accepted activation clears and starts the activation timer, enters converge.
// - Quiet request returns every non-power-up state to power-up.
// - Converge sends acquire with defect bit set while equalizer trains.
// - Converged goes to frame search; convergence limit reached returns to power-up.
// - Frame search sends acquire with defect; active after 100 ms stable framing.
// - Frame search returns to power-up when activation timeout is reached.
// - Active sends data and tracks steady-state versus idle sub-state.
// - Idle: remote flag triggers acknowledge message, then back-to-service control.
// - Parameter change sends new values, then change-confirm unless refused.
// - After change-confirm, remote trigger bit at 1 enters trigger state.
// - Back-to-service in idle sends return confirm, then waits remote trigger.
// - Idle request in steady state sends idle request, then waits remote trigger.
// - No remote trigger within handshake timeout keeps parameters, stays active.
// - Handshake timeout is 1000 ms.
// - Upstream loss or severe frame error in active enters sync loss.
// - Sync loss sends acquire with defect; recovery to active, timeout to converge.
// - Frame recovery timeout is 200 ms.
// - Trigger state sends trigger signal with office trigger bit for 50 ms.
// - Trigger end loads current set per last confirm, applies it, returns active.
// - Entering active from trigger copies current set into resume set.
// - Both sides switch parameters within 50 ms of each other.
module olf_office_fsm #(
  parameter int unsigned MS_TICK_CYCLES = olf_pkg::MS_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic        upstream_signal_loss_i,
  input  wire logic        upstream_energy_i,
  input  wire logic        upstream_severe_frame_error_i,
  input  wire logic        eq_converged_i,
  input  wire logic        frame_locked_i,
  input  wire logic        remote_flag_i,
  input  wire logic        remote_trigger_i,
  input  wire logic        msg_done_i,
  input  wire logic        msg_utc_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [1:0]       tx_signal_o,
  output logic             defect_indicator_o,
  output logic             office_trigger_o,
  output logic [7:0]       current_param_set_o,
  output logic             apply_params_o,
  output logic             msg_valid_o,
  output logic [2:0]       msg_code_o,
  output logic [7:0]       msg_param_o,
  output logic             link_idle_o,
  output logic [2:0]       state_o
);

  typedef struct packed {
    olf_pkg::olf_state_t state;
    olf_pkg::olf_sub_t   sub;
    olf_pkg::olf_kind_t  kind;
    logic                link_idle;
    logic                bserv;
    logic [17:0]         ms_pre;
    logic [15:0]         st_ms;
    logic [15:0]         act_ms;
    logic                quiet;
    logic                connect;
    logic                disconnect_control;
    logic                pend_pu;
    logic                pend_chg;
    logic                pend_idle;
    logic                pend_bserv;
    logic [15:0]         pu_ms;
    logic [15:0]         conv_ms;
    logic [15:0]         act_to_ms;
    logic [7:0]          prm_new;
    logic [7:0]          prm_wr;
    logic [7:0]          prm_idle;
    logic [7:0]          prm_stored;
    logic [7:0]          prm_cur;
    logic [7:0]          prm_resume;
    logic                apply;
    logic                msg_valid;
    logic [2:0]          msg_code;
    logic [7:0]          msg_param;
    logic [1:0]          tx;
    logic                defect;
    logic                otrig;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } olf_regs_t;

  olf_regs_t r;
  olf_regs_t n;

  // Address decode shared by read path and write path
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == olf_pkg::OFS_CTRL)    || (a == olf_pkg::OFS_STATUS)  ||
                  (a == olf_pkg::OFS_PU_MS)   || (a == olf_pkg::OFS_CONV_MS) ||
                  (a == olf_pkg::OFS_ACT_MS)  || (a == olf_pkg::OFS_SETS)    ||
                  (a == olf_pkg::OFS_CURRENT);
  endfunction : addr_mapped

  // Clamp keeps quiet-detection time inside its legal window
  function automatic logic [15:0] clamp_pu(input logic [15:0] v);
    if (v < olf_pkg::PU_MIN_MS) begin
      clamp_pu = olf_pkg::PU_MIN_MS;
    end else if (v > olf_pkg::PU_MAX_MS) begin
      clamp_pu = olf_pkg::PU_MAX_MS;
    end else begin
      clamp_pu = v;
    end
  endfunction : clamp_pu

  logic        tick;
  logic        restart;
  logic        go_powerup;
  logic        bus_acc;
  logic [31:0] rd_word;

  // Next-state logic for the whole block
  always_comb begin
    n          = r;
    restart    = 1'b0;
    go_powerup = 1'b0;
    n.apply    = 1'b0;
    n.pready   = 1'b0;
    n.pslverr  = 1'b0;
    tick       = (r.ms_pre == 18'(MS_TICK_CYCLES - 1));
    bus_acc    = psel_i && penable_i;

    // Millisecond time base; both timers saturate
    n.ms_pre = tick ? 18'h00000 : r.ms_pre + 18'h00001;
    if (tick && (r.st_ms != 16'hFFFF)) begin
      n.st_ms = r.st_ms + olf_pkg::ONE_MS;
    end
    if (tick && (r.act_ms != 16'hFFFF)) begin
      n.act_ms = r.act_ms + olf_pkg::ONE_MS;
    end

    // Main state machine
    unique case (r.state)
      olf_pkg::powerup_state: begin
        n.prm_cur = r.prm_stored;
        n.apply   = 1'b1;
        if (!upstream_signal_loss_i) begin
          restart = 1'b1;
        end else if (r.st_ms > r.pu_ms) begin
          n.state = olf_pkg::standby_state;
          restart = 1'b1;
        end
      end
      olf_pkg::standby_state: begin
        if (r.quiet) begin
          go_powerup = 1'b1;
        end else if (r.connect || (upstream_energy_i && !r.disconnect_control)) begin
          n.state  = olf_pkg::converge_state;
          n.act_ms = '0;
          restart  = 1'b1;
        end
      end
      olf_pkg::converge_state: begin
        if (r.quiet || upstream_signal_loss_i) begin
          go_powerup = 1'b1;
        end else if (eq_converged_i) begin
          n.state = olf_pkg::frame_search_state;
          restart = 1'b1;
        end else if (r.act_ms >= r.conv_ms) begin
          go_powerup = 1'b1;
        end
      end
      olf_pkg::frame_search_state: begin
        if (r.quiet || upstream_signal_loss_i || (r.act_ms >= r.act_to_ms)) begin
          go_powerup = 1'b1;
        end else if (!frame_locked_i) begin
          restart = 1'b1;
        end else if (r.st_ms >= olf_pkg::STABLE_MS) begin
          n.state = olf_pkg::active_state;
          n.sub   = olf_pkg::sub_none;
        end
      end
      olf_pkg::active_state: begin
        if (r.quiet) begin
          go_powerup = 1'b1;
        end else if (upstream_signal_loss_i || upstream_severe_frame_error_i) begin
          n.state     = olf_pkg::sync_loss_state;
          n.sub       = olf_pkg::sub_none;
          n.msg_valid = 1'b0;
          restart     = 1'b1;
        end else begin
          unique case (r.sub)
            olf_pkg::sub_none: begin
              if (r.link_idle && (r.pend_bserv || r.bserv)) begin
                n.bserv      = 1'b1;
                n.pend_bserv = 1'b0;
                n.sub        = olf_pkg::sub_rts_msg;
                n.msg_valid  = 1'b1;
                n.msg_code   = olf_pkg::MSG_RTS_CONF;
                n.msg_param  = r.prm_wr;
              end else if (r.link_idle && remote_flag_i) begin
                n.sub       = olf_pkg::sub_ack_msg;
                n.msg_valid = 1'b1;
                n.msg_code  = olf_pkg::MSG_SRV_ACK;
                n.msg_param = olf_pkg::PRM_RESET;
              end else if (r.pend_chg) begin
                n.pend_chg  = 1'b0;
                n.sub       = olf_pkg::sub_prm_msg;
                n.msg_valid = 1'b1;
                n.msg_code  = olf_pkg::MSG_PARAM;
                n.msg_param = r.prm_new;
              end else if (!r.link_idle && r.pend_idle) begin
                n.pend_idle = 1'b0;
                n.sub       = olf_pkg::sub_idle_msg;
                n.msg_valid = 1'b1;
                n.msg_code  = olf_pkg::MSG_IDLE_REQ;
                n.msg_param = r.prm_idle;
              end
            end
            olf_pkg::sub_ack_msg: begin
              if (msg_done_i) begin
                n.msg_valid = 1'b0;
                n.bserv     = 1'b1;
                n.sub       = olf_pkg::sub_none;
              end
            end
            olf_pkg::sub_prm_msg: begin
              if (msg_utc_i) begin
                n.msg_valid = 1'b0;
                n.sub       = olf_pkg::sub_none;
              end else if (msg_done_i) begin
                n.sub       = olf_pkg::sub_chg_msg;
                n.msg_code  = olf_pkg::MSG_CHANGE;
              end
            end
            olf_pkg::sub_chg_msg, olf_pkg::sub_rts_msg, olf_pkg::sub_idle_msg: begin
              if (msg_utc_i) begin
                n.msg_valid = 1'b0;
                n.sub       = olf_pkg::sub_none;
              end else if (msg_done_i) begin
                n.msg_valid = 1'b0;
                n.sub       = olf_pkg::sub_wait_trig;
                restart     = 1'b1;
                n.kind      = (r.sub == olf_pkg::sub_chg_msg) ? olf_pkg::kind_change :
                              (r.sub == olf_pkg::sub_rts_msg) ? olf_pkg::kind_resume :
                                                                olf_pkg::kind_idle;
              end
            end
            olf_pkg::sub_wait_trig: begin
              if (remote_trigger_i) begin
                n.state = olf_pkg::trigger_state;
                n.sub   = olf_pkg::sub_none;
                restart = 1'b1;
              end else if (r.st_ms >= olf_pkg::HSHAKE_MS) begin
                n.sub   = olf_pkg::sub_none;
              end
            end
            default: begin
              n.sub = olf_pkg::sub_none;
            end
          endcase
        end
      end
      olf_pkg::sync_loss_state: begin
        if (r.quiet) begin
          go_powerup = 1'b1;
        end else if (frame_locked_i && !upstream_signal_loss_i) begin
          n.state = olf_pkg::active_state;
        end else if (r.st_ms >= olf_pkg::SYNC_MS) begin
          n.state  = olf_pkg::converge_state;
          n.act_ms = '0;
          restart  = 1'b1;
        end
      end
      olf_pkg::trigger_state: begin
        if (r.quiet) begin
          go_powerup = 1'b1;
        end else if (tick && (r.st_ms == olf_pkg::TRIG_MS - olf_pkg::ONE_MS)) begin
          n.state   = olf_pkg::active_state;
          n.apply   = 1'b1;
          unique case (r.kind)
            olf_pkg::kind_change: n.prm_cur = r.prm_new;
            olf_pkg::kind_resume: n.prm_cur = r.prm_wr;
            default:              n.prm_cur = r.prm_idle;
          endcase
          n.prm_resume = n.prm_cur;
          n.link_idle  = (r.kind == olf_pkg::kind_idle);
          n.bserv      = 1'b0;
        end
      end
      default: begin
        go_powerup = 1'b1;
      end
    endcase

    // Power-up request is honoured only outside power-up itself
    if (r.pend_pu) begin
      n.pend_pu = 1'b0;
      if (r.state != olf_pkg::powerup_state) begin
        go_powerup = 1'b1;
      end
    end
    if (go_powerup) begin
      n.state     = olf_pkg::powerup_state;
      n.sub       = olf_pkg::sub_none;
      n.msg_valid = 1'b0;
      n.bserv     = 1'b0;
      n.link_idle = 1'b0;
      n.pend_chg  = 1'b0;
      n.pend_idle = 1'b0;
      n.apply     = 1'b1;
      n.prm_cur   = r.prm_stored;
      restart     = 1'b1;
    end
    // Restarting the prescaler makes state timers exact to the cycle
    if (restart) begin
      n.st_ms  = '0;
      n.ms_pre = '0;
    end

    // APB: first access cycle loads read data, second one completes
    rd_word = olf_pkg::ZERO32;
    unique case (paddr_i)
      olf_pkg::OFS_CTRL:    rd_word = {29'h0, r.disconnect_control, r.connect, r.quiet};
      olf_pkg::OFS_STATUS:  rd_word = {22'h0, r.bserv, r.link_idle, r.kind,
                                       r.sub, r.state};
      olf_pkg::OFS_PU_MS:   rd_word = {16'h0, r.pu_ms};
      olf_pkg::OFS_CONV_MS: rd_word = {16'h0, r.conv_ms};
      olf_pkg::OFS_ACT_MS:  rd_word = {16'h0, r.act_to_ms};
      olf_pkg::OFS_SETS:    rd_word = {r.prm_stored, r.prm_idle, r.prm_wr, r.prm_new};
      olf_pkg::OFS_CURRENT: rd_word = {16'h0, r.prm_resume, r.prm_cur};
      default:              rd_word = olf_pkg::ZERO32;
    endcase
    if (bus_acc && !r.pready) begin
      n.pready  = 1'b1;
      n.prdata  = pwrite_i ? olf_pkg::ZERO32 : rd_word;
      n.pslverr = !addr_mapped(paddr_i);
    end
    // Writes land at the completing edge; software sets win over clears
    if (bus_acc && r.pready && pwrite_i) begin
      unique case (paddr_i)
        olf_pkg::OFS_CTRL: begin
          n.quiet   = pwdata_i[olf_pkg::CB_QUIET];
          n.connect = pwdata_i[olf_pkg::CB_CONNECT];
          n.disconnect_control  = pwdata_i[olf_pkg::CB_DISCONNECT_CONTROL];
          if (pwdata_i[olf_pkg::CB_POWERUP]) n.pend_pu    = 1'b1;
          if (pwdata_i[olf_pkg::CB_PCHANGE]) n.pend_chg   = 1'b1;
          if (pwdata_i[olf_pkg::CB_IDLE_REQUEST_MSG]) n.pend_idle  = 1'b1;
          if (pwdata_i[olf_pkg::CB_BSERV])   n.pend_bserv = 1'b1;
        end
        olf_pkg::OFS_PU_MS:   n.pu_ms     = clamp_pu(pwdata_i[15:0]);
        olf_pkg::OFS_CONV_MS: n.conv_ms   = pwdata_i[15:0];
        olf_pkg::OFS_ACT_MS:  n.act_to_ms = pwdata_i[15:0];
        olf_pkg::OFS_SETS: begin
          n.prm_new    = pwdata_i[7:0];
          n.prm_wr     = pwdata_i[15:8];
          n.prm_idle   = pwdata_i[23:16];
          n.prm_stored = pwdata_i[31:24];
        end
        default: ;
      endcase
    end

    // Line signalling follows the state being entered
    n.otrig  = 1'b0;
    n.defect = 1'b0;
    unique case (n.state)
      olf_pkg::converge_state, olf_pkg::frame_search_state, olf_pkg::sync_loss_state: begin
        n.tx     = olf_pkg::TX_ACQUIRE;
        n.defect = 1'b1;
      end
      olf_pkg::active_state:  n.tx = olf_pkg::TX_DATA;
      olf_pkg::trigger_state: begin
        n.tx    = olf_pkg::TX_TRIG;
        n.otrig = 1'b1;
      end
      default:                n.tx = olf_pkg::TX_QUIET;
    endcase
  end

  // Single state register; synchronous active-low reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r           <= '0;
      r.state     <= olf_pkg::powerup_state;
      r.pu_ms     <= olf_pkg::PU_MAX_MS;
      r.conv_ms   <= olf_pkg::CONV_DEF_MS;
      r.act_to_ms <= olf_pkg::ACT_DEF_MS;
      r.tx        <= olf_pkg::TX_QUIET;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata_o            = r.prdata;
  assign pready_o            = r.pready;
  assign pslverr_o           = r.pslverr;
  assign tx_signal_o         = r.tx;
  assign defect_indicator_o  = r.defect;
  assign office_trigger_o    = r.otrig;
  assign current_param_set_o = r.prm_cur;
  assign apply_params_o      = r.apply;
  assign msg_valid_o         = r.msg_valid;
  assign msg_code_o          = r.msg_code;
  assign msg_param_o         = r.msg_param;
  assign link_idle_o         = r.link_idle;
  assign state_o             = r.state;

endmodule : olf_office_fsm

/* File: olf_pkg.sv */
// Constants and types for the office-side link activation controller.
// Assumes a 200 MHz ref_clk_i and APB with 32-bit data.
package olf_pkg;
  // Clock and time base
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned MS_PER_US      = 1000;
  localparam int unsigned MS_CYCLES      = CLK_MHZ * MS_PER_US; // cycles in one ms
  // Timer figures in ms
  localparam logic [15:0] PU_MIN_MS      = 16'h000A; // 10 ms
  localparam logic [15:0] PU_MAX_MS      = 16'h0064; // 100 ms
  localparam logic [15:0] CONV_DEF_MS    = 16'h0FA0; // 4000 ms
  localparam logic [15:0] ACT_DEF_MS     = 16'h2710; // 10000 ms
  localparam logic [15:0] STABLE_MS      = 16'h0064; // 100 ms
  localparam logic [15:0] HSHAKE_MS      = 16'h03E8; // 1000 ms
  localparam logic [15:0] SYNC_MS        = 16'h00C8; // 200 ms
  localparam logic [15:0] TRIG_MS        = 16'h0032; // 50 ms
  localparam logic [15:0] ONE_MS         = 16'h0001;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_PU_MS      = 8'h08;
  localparam logic [7:0]  OFS_CONV_MS    = 8'h0C;
  localparam logic [7:0]  OFS_ACT_MS     = 8'h10;
  localparam logic [7:0]  OFS_SETS       = 8'h14;
  localparam logic [7:0]  OFS_CURRENT    = 8'h18;
  // Control register bits
  localparam int          CB_QUIET       = 0;
  localparam int          CB_CONNECT     = 1;
  localparam int          CB_DISCONNECT_CONTROL      = 2;
  localparam int          CB_POWERUP     = 3;
  localparam int          CB_PCHANGE     = 4;
  localparam int          CB_IDLE_REQUEST_MSG     = 5;
  localparam int          CB_BSERV       = 6;
  // Transmit signal kinds
  localparam logic [1:0]  TX_QUIET       = 2'h0;
  localparam logic [1:0]  TX_ACQUIRE     = 2'h1;
  localparam logic [1:0]  TX_TRIG        = 2'h2;
  localparam logic [1:0]  TX_DATA        = 2'h3;
  // Overhead message channel codes
  localparam logic [2:0]  MSG_PARAM      = 3'h1;
  localparam logic [2:0]  MSG_CHANGE     = 3'h2;
  localparam logic [2:0]  MSG_SRV_ACK    = 3'h3;
  localparam logic [2:0]  MSG_RTS_CONF   = 3'h4;
  localparam logic [2:0]  MSG_IDLE_REQ   = 3'h5;
  // Reset values
  localparam logic [7:0]  PRM_RESET      = 8'h00;
  localparam logic [31:0] ZERO32         = 32'h0000_0000;

  typedef enum logic [2:0] {
    powerup_state, standby_state, converge_state, frame_search_state,
    active_state, sync_loss_state, trigger_state
  } olf_state_t;

  typedef enum logic [2:0] {
    sub_none, sub_prm_msg, sub_chg_msg, sub_ack_msg, sub_rts_msg,
    sub_idle_msg, sub_wait_trig
  } olf_sub_t;

  typedef enum logic [1:0] {
    kind_change, kind_resume, kind_idle
  } olf_kind_t;
endpackage : olf_pkg

/* File: olf_chk.sv */
// Port checker for the office link activation controller.
// Assumes a bind onto olf_office_fsm; sees only its ports.
`timescale 1ns/1ps
module olf_chk #(
  parameter int unsigned MS_TICK_CYCLES = 10
) (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       remote_trigger_i,
  input wire logic       upstream_severe_frame_error_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic [1:0] tx_signal_o,
  input wire logic       defect_indicator_o,
  input wire logic       office_trigger_o,
  input wire logic       apply_params_o,
  input wire logic [2:0] state_o
);
  localparam int unsigned TRIG_CYC = 50 * MS_TICK_CYCLES;
  logic [31:0] trig_cnt;
  // Trigger dwell counter; far too long for a repetition
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) trig_cnt <= 32'h0;
    else trig_cnt <= (state_o == 3'h6) ? trig_cnt + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_trig_bit; office_trigger_o == (state_o == 3'h6); endproperty
  a_trig_bit: assert property (p_trig_bit) else $error("office trigger bit wrong");
  property p_defect; defect_indicator_o == (state_o inside {3'h2, 3'h3, 3'h5}); endproperty
  a_defect: assert property (p_defect) else $error("defect bit wrong");
  property p_quiet; state_o inside {3'h0, 3'h1} |-> tx_signal_o == olf_pkg::TX_QUIET; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet not sent");
  property p_data; state_o == 3'h4 |-> tx_signal_o == olf_pkg::TX_DATA; endproperty
  a_data: assert property (p_data) else $error("data not sent");
  property p_apply_pu; state_o == 3'h0 && $past(rstn_i) |-> apply_params_o; endproperty
  a_apply_pu: assert property (p_apply_pu) else $error("stored set not applied");
  property p_trig_len;
    $fell(state_o == 3'h6) && state_o == 3'h4 |-> trig_cnt == TRIG_CYC;
  endproperty
  a_trig_len: assert property (p_trig_len) else $error("trigger length wrong");
  property p_trig_in; $rose(state_o == 3'h6) |-> $past(remote_trigger_i); endproperty
  a_trig_in: assert property (p_trig_in) else $error("trigger without remote bit");
  property p_sef;
    state_o == 3'h4 && upstream_severe_frame_error_i |=> state_o inside {3'h5, 3'h0};
  endproperty
  a_sef: assert property (p_sef) else $error("frame error not acted on");
  property p_ready; psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o; endproperty
  a_ready: assert property (p_ready) else $error("bus answer timing wrong");
  property p_slverr; pslverr_o |-> pready_o; endproperty
  a_slverr: assert property (p_slverr) else $error("error without ready");
  c_trig: cover property (state_o == 3'h6);
  c_sync: cover property (state_o == 3'h5);
  c_err: cover property (pslverr_o);
endmodule : olf_chk

bind olf_office_fsm olf_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_chk (
  .ref_clk_i, .rstn_i, .psel_i, .penable_i, .remote_trigger_i, .upstream_severe_frame_error_i,
  .pready_o, .pslverr_o, .tx_signal_o, .defect_indicator_o, .office_trigger_o,
  .apply_params_o, .state_o);

/* File: olf_remote.sv */
// Remote transceiver model: line status, message delivery, remote trigger.
// Assumes the bench decides when the remote transmits and answers confirms.
`timescale 1ns/1ps
module olf_remote (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       line_up_i,
  input  wire logic       trig_en_i,
  input  wire logic [1:0] tx_signal_i,
  input  wire logic       msg_valid_i,
  input  wire logic [2:0] msg_code_i,
  input  wire logic       office_trigger_i,
  output logic            loss_o,
  output logic            energy_o,
  output logic            lock_o,
  output logic            rtrig_o,
  output logic            done_o
);
  logic [1:0] dly;
  // Lock only while the office sends something
  assign loss_o = !line_up_i;
  assign energy_o = line_up_i;
  assign lock_o = line_up_i && tx_signal_i != olf_pkg::TX_QUIET;
  // Slow delivery: four cycles per message
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dly <= 2'h0;
      done_o <= 1'b0;
      rtrig_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (msg_valid_i && !done_o) dly <= dly + 2'h1;
      if (msg_valid_i && !done_o && dly == 2'h3) begin
        done_o <= 1'b1;
        if (trig_en_i && msg_code_i inside {3'h2, 3'h4, 3'h5}) rtrig_o <= 1'b1;
      end
      if (office_trigger_i) rtrig_o <= 1'b0;
    end
  end
endmodule : olf_remote

/* File: tb.sv */
// Testbench for the office link activation controller.
// Assumes a 10-cycle ms tick and the remote model on the line side.
`timescale 1ns/1ps
module tb;
  logic        ref_clk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, line_up = 0;
  logic        trig_en = 1, sef = 0, pready, pslverr, apply, otrig, defect, idle, flag = 0;
  logic        mvalid, loss, energy, lock, rtrig, done;
  logic [1:0]  tx;
  logic [2:0]  state, mcode;
  logic [7:0]  paddr = 8'h00, cur, mpar;
  logic [31:0] pwdata = 32'h0, prdata;
  int          failures = 0, tests_run = 0;
  olf_office_fsm #(.MS_TICK_CYCLES(10)) i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata),
    .upstream_signal_loss_i(loss), .upstream_energy_i(energy),
    .upstream_severe_frame_error_i(sef), .eq_converged_i(lock), .frame_locked_i(lock),
    .remote_flag_i(flag), .remote_trigger_i(rtrig), .msg_done_i(done), .msg_utc_i(1'b0),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_signal_o(tx),
    .defect_indicator_o(defect), .office_trigger_o(otrig), .current_param_set_o(cur),
    .apply_params_o(apply), .msg_valid_o(mvalid), .msg_code_o(mcode), .msg_param_o(mpar),
    .link_idle_o(idle), .state_o(state));
  olf_remote i_rem (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .line_up_i(line_up),
    .trig_en_i(trig_en), .tx_signal_i(tx), .msg_valid_i(mvalid), .msg_code_i(mcode),
    .office_trigger_i(otrig), .loss_o(loss), .energy_o(energy), .lock_o(lock),
    .rtrig_o(rtrig), .done_o(done));
  // Free-running 200 MHz clock
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; waits for pready with a bound
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    pen <= 1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
    if (n >= 20) begin
      failures++;
      end_sim();
    end
  endtask : apb
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, a, d, r, e);
  endtask : wr
  task automatic rdc(string n, logic [7:0] a, logic [31:0] x, logic xe);
    logic [31:0] r;
    logic        e;
    apb(0, a, 32'h0, r, e);
    chk(n, x, r);
    chk("pslverr", xe, e);
  endtask : rdc
  task automatic wait_st(logic [2:0] s, int lim);
    int n;
    n = 0;
    while (state !== s && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("state", s, state);
    if (state !== s) end_sim();
  endtask : wait_st
  task automatic t_reset;
    chk("state", 0, state);
    chk("apply", 1, apply);
    rdc("pu_ms", olf_pkg::OFS_PU_MS, 32'h64, 0);
    rdc("unmapped", 8'h40, 32'h0, 1);
    wr(olf_pkg::OFS_PU_MS, 32'h5);
    rdc("pu_ms", olf_pkg::OFS_PU_MS, 32'hA, 0);
    wr(olf_pkg::OFS_CONV_MS, 32'h14);
    wr(olf_pkg::OFS_ACT_MS, 32'hC8);
  endtask : t_reset
  task automatic t_activate;
    wait_st(1, 400);
    chk("tx", olf_pkg::TX_QUIET, tx);
    wr(olf_pkg::OFS_CTRL, 32'h4);
    line_up <= 1;
    repeat (50) @(posedge ref_clk_i);
    chk("state", 1, state);
    wr(olf_pkg::OFS_CTRL, 32'h0);
    wait_st(2, 20);
    chk("tx", olf_pkg::TX_ACQUIRE, tx);
    wait_st(3, 300);
    wait_st(4, 1500);
  endtask : t_activate
  task automatic t_switch(logic [31:0] ctl, logic [7:0] x, logic xi);
    wr(olf_pkg::OFS_CTRL, ctl);
    wait_st(6, 100);
    chk("otrig", 1, otrig);
    chk("param", x, mpar);
    wait_st(4, 600);
    chk("current", x, cur);
    chk("link idle", xi, idle);
    rdc("resume", olf_pkg::OFS_CURRENT, {16'h0, x, x}, 0);
  endtask : t_switch
  task automatic t_timeout;
    trig_en <= 0;
    wr(olf_pkg::OFS_CTRL, 32'h20);
    repeat (12000) @(posedge ref_clk_i);
    chk("state", 4, state);
    chk("current", 8'hA5, cur);
    trig_en <= 1;
  endtask : t_timeout
  task automatic t_sync;
    sef <= 1;
    @(posedge ref_clk_i);
    sef <= 0;
    wait_st(5, 5);
    wait_st(4, 30);
    wr(olf_pkg::OFS_CTRL, 32'h1);
    wait_st(0, 5);
  endtask : t_sync
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    t_reset();
    t_activate();
    wr(olf_pkg::OFS_SETS, 32'h003C_00A5);
    t_switch(32'h10, 8'hA5, 0);
    t_timeout();
    t_switch(32'h20, 8'h3C, 1);
    flag <= 1;
    t_switch(32'h0, 8'h00, 0);
    t_sync();
    end_sim();
  end
endmodule : tb
